// File: core/rscl_top.sv
// reset combiner, start-up sequencer and cause flags with apb access
`timescale 1ns/10ps
`default_nettype none
module rscl_top #(
    parameter int unsigned PUT_COUNT = rscl_pkg::PUT_CYCLES,
    parameter int unsigned GLITCH_COUNT = rscl_pkg::GLITCH_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_pin,
    output logic ext_reset_pin_oe,
    output logic ext_reset_pin_out,
    output logic ext_reset_pin_pullup,
    output logic ext_reset_pin_gpio,
    input wire logic pin_reset_enable,
    input wire logic low_voltage_prog,
    input wire logic powerup_timer_enable_n,
    input wire logic stack_reset_enable,
    input wire logic poweron_evt,
    input wire logic brownout_evt,
    input wire logic prog_mode_exit,
    input wire logic watchdog_timeout,
    input wire logic window_violation,
    input wire logic reset_instr,
    input wire logic stack_overflow,
    input wire logic stack_underflow,
    input wire logic sleeping,
    input wire logic watchdog_wake,
    input wire logic int_wake,
    input wire logic global_int_enable,
    output logic core_reset,
    output logic pc_load,
    output logic [15:0] pc_load_value,
    output logic wake_continue,
    output logic [7:0] power_control_flags,
    output logic timeout_flag,
    output logic powerdown_flag
);
    localparam int unsigned PW = $clog2(PUT_COUNT + 1);
    localparam int unsigned GW = $clog2(GLITCH_COUNT + 1);
    localparam logic [PW-1:0] PUT_LAST = PW'(PUT_COUNT);
    localparam logic [GW-1:0] GLITCH_LAST = GW'(GLITCH_COUNT);
    localparam logic [3:0] START_LAST = 4'(rscl_pkg::START_CYCLES);

    typedef struct packed {
        rscl_pkg::rscl_state_t state;
        logic [PW-1:0] put_cnt;
        logic put_done;
        logic [GW-1:0] flt_cnt;
        logic pin_low;
        logic [3:0] start_cnt;
        logic [7:0] pwr_flags;
        logic timeout;
        logic powerdown;
        logic sw_pullup;
        logic pc_load;
        logic [15:0] pc_val;
        logic wake;
        logic [31:0] rdata;
    } rscl_reg_t;

    rscl_reg_t s_q;
    rscl_reg_t s_d;
    logic pin_en;
    logic hold_pin;
    logic power_evt;
    logic stack_rst;
    logic soft_rst;
    logic apb_acc;
    logic addr_ok;

    function automatic logic [7:0] rscl_fw_write(input logic [7:0] cur, input logic [7:0] wr);
        // sticky-high flags may be cleared, active-low flags may be set; hardware wins elsewhere
        rscl_fw_write = wr;
        rscl_fw_write[rscl_pkg::PC_STACK_OVER] = cur[rscl_pkg::PC_STACK_OVER] & wr[rscl_pkg::PC_STACK_OVER];
        rscl_fw_write[rscl_pkg::PC_STACK_UNDER] = cur[rscl_pkg::PC_STACK_UNDER] & wr[rscl_pkg::PC_STACK_UNDER];
    endfunction

    always_comb begin
        pin_en = pin_reset_enable | low_voltage_prog; // (R23)
        power_evt = poweron_evt | brownout_evt | prog_mode_exit; // (R9)
        stack_rst = stack_reset_enable & (stack_overflow | stack_underflow); // (R8)
        hold_pin = pin_en & s_q.pin_low; // (R1)
        soft_rst = watchdog_timeout | window_violation | reset_instr | stack_rst; // (R5)
        apb_acc = psel & penable;
        addr_ok = (paddr == rscl_pkg::REG_POWER_CTRL) | (paddr == rscl_pkg::REG_STATUS) |
            (paddr == rscl_pkg::REG_CAUSE_EVT);
        s_d = s_q;
        s_d.pc_load = 1'b0;
        s_d.wake = 1'b0;
        // glitch filter: pin must stay at a new level for the full count
        if (ext_reset_pin == s_q.pin_low) begin // (R2)
            if (s_d.flt_cnt == GLITCH_LAST) begin
                s_d.pin_low = ~ext_reset_pin;
                s_d.flt_cnt = '0;
            end else begin
                s_d.flt_cnt = s_q.flt_cnt + GW'(1);
            end
        end else begin
            s_d.flt_cnt = '0;
        end
        // firmware access first so hardware events below win
        if (apb_acc & pwrite) begin
            if (paddr == rscl_pkg::REG_POWER_CTRL) begin
                s_d.pwr_flags = rscl_fw_write(s_q.pwr_flags, pwdata[7:0]); // (R24)
            end
            if (paddr == rscl_pkg::REG_STATUS) begin
                s_d.sw_pullup = pwdata[rscl_pkg::ST_PULLUP]; // (R4)
            end
        end
        // power-up timer runs independent of the pin
        if (!s_q.put_done) begin // (R12)
            if (powerup_timer_enable_n || s_q.put_cnt == PUT_LAST) begin // (R10) (R22)
                s_d.put_done = 1'b1;
            end else begin
                s_d.put_cnt = s_q.put_cnt + PW'(1);
            end
        end
        unique case (s_q.state)
            rscl_pkg::RSCL_HOLD: begin
                s_d.state = rscl_pkg::RSCL_WAIT;
            end
            rscl_pkg::RSCL_WAIT: begin
                if (s_q.put_done && !hold_pin) begin // (R11)
                    s_d.state = rscl_pkg::RSCL_START;
                    s_d.start_cnt = '0;
                end
            end
            rscl_pkg::RSCL_START: begin
                if (hold_pin) begin
                    s_d.state = rscl_pkg::RSCL_WAIT;
                end else if (s_q.start_cnt == START_LAST - 4'h1) begin // (R12)
                    s_d.state = rscl_pkg::RSCL_RUN;
                    s_d.pc_load = 1'b1; // (R21)
                    s_d.pc_val = rscl_pkg::RESET_VECTOR;
                end else begin
                    s_d.start_cnt = s_q.start_cnt + 4'h1;
                end
            end
            rscl_pkg::RSCL_RUN: begin
                if (hold_pin) begin
                    s_d.pwr_flags[rscl_pkg::PC_PIN] = 1'b0; // (R18)
                    if (sleeping) begin
                        s_d.timeout = 1'b1; // (R19)
                        s_d.powerdown = 1'b0;
                    end
                    s_d.state = rscl_pkg::RSCL_WAIT; // (R25)
                end else if (soft_rst) begin
                    if (window_violation) begin
                        s_d.pwr_flags[rscl_pkg::PC_WINDOW] = 1'b0; // (R6)
                        s_d.timeout = 1'b1;
                    end
                    if (watchdog_timeout) begin
                        s_d.pwr_flags[rscl_pkg::PC_WATCHDOG] = 1'b0; // (R16)
                        s_d.timeout = 1'b0;
                    end
                    if (reset_instr) begin
                        s_d.pwr_flags[rscl_pkg::PC_INSTR] = 1'b0; // (R7)
                    end
                    if (stack_rst && stack_overflow) begin
                        s_d.pwr_flags[rscl_pkg::PC_STACK_OVER] = 1'b1; // (R8)
                    end
                    if (stack_rst && stack_underflow) begin
                        s_d.pwr_flags[rscl_pkg::PC_STACK_UNDER] = 1'b1;
                    end
                    s_d.state = rscl_pkg::RSCL_START; // (R21)
                    s_d.start_cnt = '0;
                end else if (sleeping && watchdog_wake) begin
                    s_d.timeout = 1'b0; // (R17)
                    s_d.powerdown = 1'b0;
                    s_d.wake = 1'b1;
                end else if (sleeping && int_wake) begin
                    s_d.timeout = 1'b1; // (R20)
                    s_d.powerdown = 1'b0;
                    s_d.wake = 1'b1;
                    if (global_int_enable) begin
                        s_d.pc_load = 1'b1;
                        s_d.pc_val = rscl_pkg::INT_VECTOR;
                    end
                end
            end
        endcase
        // power events restart the sequencer and power-up timer like a fresh power-on
        if (power_evt) begin
            s_d.state = rscl_pkg::RSCL_HOLD;
            s_d.put_cnt = '0;
            s_d.put_done = 1'b0;
            s_d.timeout = 1'b1; // (R14)
            s_d.powerdown = 1'b1;
            if (poweron_evt || prog_mode_exit) begin
                s_d.pwr_flags = rscl_pkg::PWR_FLAGS_POR_VAL; // (R13)
                s_d.pwr_flags[rscl_pkg::PC_BROWNOUT] = s_q.pwr_flags[rscl_pkg::PC_BROWNOUT];
            end else begin
                s_d.pwr_flags[rscl_pkg::PC_STACK_OVER] = 1'b0; // (R15)
                s_d.pwr_flags[rscl_pkg::PC_STACK_UNDER] = 1'b0;
                s_d.pwr_flags[rscl_pkg::PC_PIN] = 1'b1;
                s_d.pwr_flags[rscl_pkg::PC_INSTR] = 1'b1;
                s_d.pwr_flags[rscl_pkg::PC_BROWNOUT] = 1'b0;
            end
        end
        // read data registered in the setup phase
        s_d.rdata = '0;
        if (psel && !penable && !pwrite) begin
            if (paddr == rscl_pkg::REG_POWER_CTRL) begin
                s_d.rdata = {24'h000000, s_q.pwr_flags};
            end else if (paddr == rscl_pkg::REG_STATUS) begin
                s_d.rdata = {29'h00000000, s_q.sw_pullup, s_q.timeout, s_q.powerdown};
            end else if (paddr == rscl_pkg::REG_CAUSE_EVT) begin
                s_d.rdata = {29'h00000000, s_q.pin_low, s_q.state};
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.state <= rscl_pkg::RSCL_HOLD;
            s_q.pwr_flags <= rscl_pkg::PWR_FLAGS_POR_VAL;
            s_q.timeout <= rscl_pkg::STAT_POR_VAL[rscl_pkg::ST_TIMEOUT];
            s_q.powerdown <= rscl_pkg::STAT_POR_VAL[rscl_pkg::ST_POWERDOWN];
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        pready = 1'b1;
        pslverr = apb_acc & ~addr_ok;
        prdata = s_q.rdata;
        ext_reset_pin_oe = 1'b0; // (R3)
        ext_reset_pin_out = 1'b0;
        ext_reset_pin_pullup = pin_en | s_q.sw_pullup; // (R1) (R4)
        ext_reset_pin_gpio = ~pin_en & ext_reset_pin; // (R4)
        core_reset = (s_q.state != rscl_pkg::RSCL_RUN); // (R25)
        pc_load = s_q.pc_load;
        pc_load_value = s_q.pc_val;
        wake_continue = s_q.wake;
        power_control_flags = s_q.pwr_flags;
        timeout_flag = s_q.timeout;
        powerdown_flag = s_q.powerdown;
    end
endmodule
`default_nettype wire

// File: include/rscl_pkg.sv
// package of constants and types for the reset source and cause logic
// Contract
// (R1) pin reset enabled and pin low holds the device in reset, weak pull-up on
// (R2) a filter on the pin path ignores short glitch pulses
// (R3) no internal source drives the reset pin low; it is input only
// (R4) pin reset disabled: pin is a general input, software owns the pull-up
// (R5) watchdog timeout resets and updates timeout and powerdown flags; the code clears only the timeout flag and keeps powerdown
// (R6) window violation reset clears violation flag, sets timeout, pc to zero
// (R7) reset instruction resets and clears the reset instruction flag
// (R8) stack over or underflow resets only if enabled, and sets its flag
// (R9) programming mode exit acts exactly like a power-on reset
// (R10) power-up timer optionally delays after power-on or brown-out, active-low enable
// (R11) run waits for power-up timer and pin release after power or brown-out
// (R12) timer runs independent of pin; pin release after expiry starts in 10 cycles
// (R13) power-on sets power flags 0011 110x and status 1 1000
// (R14) power-on always sets the timeout flag
// (R15) brown-out sets power flags 00uu 11u0, timeout and powerdown set
// (R16) watchdog timeout reset clears watchdog flag and timeout flag, pc zero
// (R17) watchdog wake clears timeout and powerdown, keeps power flags, no reset
// (R18) pin reset in run clears only the pin reset flag
// (R19) pin reset in sleep clears pin flag, sets timeout, clears powerdown
// (R20) interrupt wake sets timeout, clears powerdown; vector 0004h if enabled
// (R21) every true reset loads pc 0000h; wake-ups do not
// (R22) power-up timer nominal 64 ms, enabled when its config bit is clear
// (R23) pin reset enabled if pin enable or low voltage programming is 1
// (R24) hardware clears active-low cause flags; firmware sets them to re-arm
// (R25) all sources combine into one reset, release synchronised to clock
package rscl_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned PUT_MS = 64;
    localparam int unsigned PUT_CYCLES = PUT_MS * 1000 * CLK_MHZ;
    localparam int unsigned START_CYCLES = 10;
    localparam int unsigned GLITCH_CYCLES = 4;
    localparam logic [31:0] REG_POWER_CTRL = 32'h0000_0000;
    localparam logic [31:0] REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] REG_CAUSE_EVT = 32'h0000_0008;
    localparam int unsigned PC_STACK_OVER = 7;
    localparam int unsigned PC_STACK_UNDER = 6;
    localparam int unsigned PC_WINDOW = 5;
    localparam int unsigned PC_WATCHDOG = 4;
    localparam int unsigned PC_PIN = 3;
    localparam int unsigned PC_INSTR = 2;
    localparam int unsigned PC_POWERON = 1;
    localparam int unsigned PC_BROWNOUT = 0;
    localparam int unsigned ST_TIMEOUT = 1;
    localparam int unsigned ST_POWERDOWN = 0;
    localparam int unsigned ST_PULLUP = 2;
    localparam logic [7:0] PWR_FLAGS_POR_VAL = 8'h3C;
    localparam logic [1:0] STAT_POR_VAL = 2'h3;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] INT_VECTOR = 16'h0004;
    typedef enum logic [1:0] {
        RSCL_HOLD = 2'b00,
        RSCL_WAIT = 2'b01,
        RSCL_START = 2'b11,
        RSCL_RUN = 2'b10
    } rscl_state_t;
endpackage

// File: bench/rscl_chk_sva.sv
// concurrent checks on the reset source and cause logic ports
`timescale 1ns/10ps
`default_nettype none
module rscl_chk (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pslverr,
    input wire logic ext_reset_pin_oe,
    input wire logic reset_instr,
    input wire logic watchdog_timeout,
    input wire logic stack_overflow,
    input wire logic stack_reset_enable,
    input wire logic int_wake,
    input wire logic sleeping,
    input wire logic core_reset,
    input wire logic pc_load,
    input wire logic [15:0] pc_load_value,
    input wire logic wake_continue,
    input wire logic [7:0] power_control_flags,
    input wire logic timeout_flag,
    input wire logic powerdown_flag
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_pin_input_only: assert property (!ext_reset_pin_oe) else $error("reset pin driven");
    a_instr_flag: assert property (reset_instr && !core_reset |=> !power_control_flags[2] && core_reset[*8])
        else $error("reset instruction flag or hold wrong");
    a_wdt_flags: assert property (watchdog_timeout && !core_reset |=> !timeout_flag && !power_control_flags[4])
        else $error("watchdog reset flags wrong");
    a_stack_gated: assert property (stack_overflow && !stack_reset_enable && !core_reset |=> !core_reset)
        else $error("stack reset while disabled");
    a_stack_flag: assert property (stack_overflow && stack_reset_enable && !core_reset |=>
        core_reset && power_control_flags[7]) else $error("stack reset missing");
    a_reset_vector: assert property ($fell(core_reset) |-> ##[0:1] (pc_load && pc_load_value == 16'h0000))
        else $error("reset vector not loaded");
    a_wake_flags: assert property (int_wake && sleeping && !core_reset |=>
        !core_reset && timeout_flag && !powerdown_flag) else $error("interrupt wake flags wrong");
    a_wake_continue: assert property (int_wake && sleeping && !core_reset |-> ##[1:2] wake_continue)
        else $error("wake continue missing");
    a_unmapped_err: assert property (psel && penable && paddr > 32'h8 |-> pslverr)
        else $error("unmapped access not refused");
endmodule
bind rscl_top rscl_chk u_chk (.core_clk, .sys_rst, .psel, .penable, .paddr, .pslverr, .ext_reset_pin_oe,
    .reset_instr, .watchdog_timeout, .stack_overflow, .stack_reset_enable, .int_wake, .sleeping, .core_reset,
    .pc_load, .pc_load_value, .wake_continue, .power_control_flags, .timeout_flag, .powerdown_flag);
`default_nettype wire

// File: bench/rscl_pin_drv.sv
// external reset pin driver model with driven-high release and glitch source
`timescale 1ns/10ps
`default_nettype none
module rscl_pin_drv (
    input wire logic core_clk,
    input wire logic hold_low,
    input wire logic glitch,
    output logic ext_reset_pin
);
    logic [1:0] g_q = 2'h0;
    always @(posedge core_clk) g_q <= glitch ? 2'h2 : (g_q != 2'h0 ? g_q - 2'h1 : 2'h0);
    // released pin is driven high by the model whatever the pull-up output is
    assign ext_reset_pin = !(hold_low || g_q != 2'h0);
endmodule
`default_nettype wire

// File: bench/testbench.sv
// self-checking testbench for the reset source and cause logic
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ext_reset_pin, core_reset;
    logic hold_low = 0, glitch = 0, sleeping = 0, int_en = 0, pin_en = 1, low_volt = 0, stk_en = 0, put_n = 0;
    logic pin_out, pin_pullup, pin_gpio, pc_load, wake_cont;
    logic [15:0] pc_vec;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [9:0] ev = 10'h000;
    logic timeout_flag, powerdown_flag;
    int mismatches = 0, samples_checked = 0;
    rscl_top #(.PUT_COUNT(20)) DUT (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_reset_pin, .ext_reset_pin_oe(), .ext_reset_pin_out(pin_out),
        .ext_reset_pin_pullup(pin_pullup), .ext_reset_pin_gpio(pin_gpio), .pin_reset_enable(pin_en),
        .low_voltage_prog(low_volt), .powerup_timer_enable_n(put_n), .stack_reset_enable(stk_en),
        .poweron_evt(ev[9]), .brownout_evt(ev[8]), .prog_mode_exit(ev[7]),
        .watchdog_timeout(ev[6]), .window_violation(ev[5]), .reset_instr(ev[4]), .stack_overflow(ev[3]),
        .stack_underflow(ev[2]), .sleeping, .watchdog_wake(ev[1]), .int_wake(ev[0]), .global_int_enable(int_en),
        .core_reset, .pc_load, .pc_load_value(pc_vec), .wake_continue(wake_cont), .power_control_flags(),
        .timeout_flag, .powerdown_flag);
    rscl_pin_drv u_pin (.core_clk, .hold_low, .glitch, .ext_reset_pin);
    initial forever #2 core_clk = ~core_clk;
    task summarize;
        if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk) penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        chk(rd, exp);
    endtask
    task pulse(input int b);
        ev[b] <= 1;
        @(posedge core_clk) ev <= 10'h000;
    endtask
    task wait_run;
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 200 && core_reset !== 1'b0; i++) @(posedge core_clk);
        @(posedge core_clk);
    endtask
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 0;
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h3C);
        rdchk(rscl_pkg::REG_STATUS, 32'h3);
        pulse(4);
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h38);
        apb(1, rscl_pkg::REG_POWER_CTRL, 32'hFF);
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h3F);
        pulse(6);
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h2F);
        pulse(3);
        repeat (12) @(posedge core_clk);
        chk(core_reset, 0);
        stk_en <= 1;
        pulse(3);
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'hAF);
        hold_low <= 1;
        repeat (20) @(posedge core_clk);
        chk(core_reset, 1);
        hold_low <= 0;
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'hA7);
        glitch <= 1;
        @(posedge core_clk) glitch <= 0;
        repeat (12) @(posedge core_clk);
        chk(core_reset, 0);
        chk({pin_out, pin_pullup, pin_gpio}, 3'b010);
        pin_en <= 0;
        @(posedge core_clk);
        chk({pin_out, pin_pullup, pin_gpio}, 3'b001);
        apb(1, rscl_pkg::REG_STATUS, 32'h4);
        chk({pin_out, pin_pullup, pin_gpio}, 3'b011);
        hold_low <= 1;
        repeat (20) @(posedge core_clk);
        chk(core_reset, 0);
        low_volt <= 1;
        repeat (20) @(posedge core_clk);
        chk(core_reset, 1);
        hold_low <= 0;
        wait_run();
        pulse(5);
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h87);
        sleeping <= 1;
        int_en <= 1;
        pulse(0);
        @(posedge core_clk);
        chk({pc_load, wake_cont, pc_vec}, {2'b11, 16'h0004});
        @(posedge core_clk);
        chk({core_reset, timeout_flag, powerdown_flag}, 3'b010);
        pulse(1);
        @(posedge core_clk);
        chk({pc_load, wake_cont}, 2'b01);
        @(posedge core_clk);
        chk({core_reset, timeout_flag, powerdown_flag}, 3'b000);
        sleeping <= 0;
        pulse(7);
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h3D);
        apb(1, rscl_pkg::REG_POWER_CTRL, 32'h03);
        put_n <= 1;
        pulse(8);
        repeat (12) @(posedge core_clk);
        chk(core_reset, 1);
        @(posedge core_clk);
        chk(core_reset, 0);
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h0E);
        rdchk(rscl_pkg::REG_STATUS, 32'h7);
        pulse(9);
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h3C);
        pulse(2);
        wait_run();
        rdchk(rscl_pkg::REG_POWER_CTRL, 32'h7C);
        rdchk(32'h0000_000C, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
